/* File: tpt_pkg.sv */
// Constants, carriers and register map of the TFT panel timing generator.
// Assumes a single 10 MHz system clock and a synchronous host bus.
package tpt_pkg;

    localparam logic [7:0] ADDR_LINE_ACTIVE_WIDTH     = 8'h16;
    localparam logic [7:0] ADDR_LINE_BLANKING_LENGTH  = 8'h18;
    localparam logic [7:0] ADDR_FRAME_HEIGHT_LOW      = 8'h1A;
    localparam logic [7:0] ADDR_FRAME_HEIGHT_HIGH     = 8'h1C;
    localparam logic [7:0] ADDR_FRAME_BLANKING_LENGTH = 8'h1E;
    localparam logic [7:0] ADDR_LINE_SYNC_WIDTH       = 8'h20;
    localparam logic [7:0] ADDR_LINE_SYNC_START       = 8'h22;
    localparam logic [7:0] ADDR_FRAME_SYNC_WIDTH      = 8'h24;
    localparam logic [7:0] ADDR_FRAME_SYNC_START      = 8'h26;
    localparam logic [7:0] ADDR_SYNC_POLARITY         = 8'h28;
    localparam logic [7:0] ADDR_FRAME_MEMORY_PORT_LOW = 8'h48;
    localparam logic [7:0] ADDR_FRAME_MEMORY_PORT_HIGH = 8'h49;
    localparam logic [7:0] ADDR_GAMMA_TABLE_DATA      = 8'h54;
    localparam logic [7:0] ADDR_POWER_SAVE_CONTROL    = 8'h56;

    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam int         WIDTH_SHIFT     = 3;

    // Bits of the polarity register; a set bit inverts the output
    localparam int POL_PCLK_BIT  = 0;
    localparam int POL_LINE_BIT  = 1;
    localparam int POL_FRAME_BIT = 2;

    // System clocks per pixel clock; even for a 50 percent duty
    localparam logic [1:0] PIXEL_DIV_LAST = 2'h3;
    localparam logic [1:0] PIXEL_DIV_HALF = 2'h2;

    localparam int CLK_PERIOD_NS     = 100;
    localparam int POWER_SAVE_MAX_NS = 20;
    localparam int POWER_SAVE_CYCLES =
        (POWER_SAVE_MAX_NS / CLK_PERIOD_NS < 1) ? 1
                                                : POWER_SAVE_MAX_NS / CLK_PERIOD_NS;

    localparam int FIFO_DEPTH  = 4;
    localparam int PIXEL_WIDTH = 18;

    typedef struct packed {
        logic        cs_n;
        logic        dc;
        logic        wr_n;
        logic        rd_n;
        logic [15:0] md;
    } tpt_bus_type;

    typedef struct packed {
        logic [17:0] pixel_data;
        logic        pclk;
        logic        line_sync;
        logic        frame_sync;
        logic        data_enable;
    } tpt_panel_type;

endpackage : tpt_pkg

/* File: tpt_timing.sv */
// Panel timing generator with host register file and pixel FIFO.
// Assumes host bus pins already synchronous to clk; one clock domain.
`timescale 1ns/1ps

module tpt_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 count;
    } tpt_fifo_state_type;

    tpt_fifo_state_type s, next_s;
    logic push, pop;

    assign in_ready  = (s.count != (AW+1)'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data  = s.mem[s.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : tpt_fifo

module tpt_timing (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire tpt_pkg::tpt_bus_type   host_bus,
    input  wire logic                   bus_width_strap,
    output logic [15:0]                 md_out,
    output logic                        md_oe,
    output logic                        mem_ready,
    output tpt_pkg::tpt_panel_type      panel
);
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr_prev;
        logic        strap;
        logic        strap_taken;
        logic [7:0]  r_width;
        logic [7:0]  r_hblank;
        logic [7:0]  r_hlow;
        logic [7:0]  r_hhigh;
        logic [7:0]  r_vblank;
        logic [7:0]  r_hsw;
        logic [7:0]  r_hps;
        logic [7:0]  r_vsw;
        logic [7:0]  r_vps;
        logic [7:0]  r_pol;
        logic [7:0]  r_ps;
        logic [7:0]  r_mem_low;
        logic [7:0]  r_gamma;
        logic [7:0]  gamma_index;
        logic [16:0] mem_addr;
        logic        byte_phase;
        logic [1:0]  div;
        logic [10:0] h;
        logic [10:0] v;
        logic        fs_low;
        logic [15:0] md_out;
        tpt_pkg::tpt_panel_type panel;
    } tpt_state_type;

    tpt_state_type s, next_s;
    logic                            wr_rise, ps_on, tick;
    logic                            push_valid, fifo_ready;
    logic                            pop, pix_valid;
    logic [tpt_pkg::PIXEL_WIDTH-1:0] push_data, pix_data;
    logic [10:0]                     htotal, vtotal, de_h0, de_v0;
    logic [10:0]                     fs_point, vn;
    logic                            de_act, hs_act;

    // Expand a 5-6-5 word to 6-6-6 by repeating the top bits
    function automatic logic [17:0] expand(input logic [15:0] w);
        return {w[15:11], w[15], w[10:5], w[4:0], w[4]};
    endfunction : expand

    function automatic logic [7:0] reg_read(input tpt_state_type st);
        unique case (st.addr)
            tpt_pkg::ADDR_LINE_ACTIVE_WIDTH:     return st.r_width;
            tpt_pkg::ADDR_LINE_BLANKING_LENGTH:  return st.r_hblank;
            tpt_pkg::ADDR_FRAME_HEIGHT_LOW:      return st.r_hlow;
            tpt_pkg::ADDR_FRAME_HEIGHT_HIGH:     return st.r_hhigh;
            tpt_pkg::ADDR_FRAME_BLANKING_LENGTH: return st.r_vblank;
            tpt_pkg::ADDR_LINE_SYNC_WIDTH:       return st.r_hsw;
            tpt_pkg::ADDR_LINE_SYNC_START:       return st.r_hps;
            tpt_pkg::ADDR_FRAME_SYNC_WIDTH:      return st.r_vsw;
            tpt_pkg::ADDR_FRAME_SYNC_START:      return st.r_vps;
            tpt_pkg::ADDR_SYNC_POLARITY:         return st.r_pol;
            tpt_pkg::ADDR_GAMMA_TABLE_DATA:      return st.r_gamma;
            tpt_pkg::ADDR_POWER_SAVE_CONTROL:    return st.r_ps;
            default:                             return 8'h00;
        endcase
    endfunction : reg_read

    // Write strobe's rising edge closes a host cycle
    assign wr_rise = !s.wr_prev && host_bus.wr_n && !host_bus.cs_n;
    assign md_oe   = !host_bus.cs_n && !host_bus.rd_n && host_bus.dc;
    assign md_out  = s.md_out;
    assign panel   = s.panel;
    assign mem_ready = fifo_ready;
    assign tick    = (s.div == tpt_pkg::PIXEL_DIV_LAST);

    tpt_fifo #(
        .WIDTH (tpt_pkg::PIXEL_WIDTH),
        .DEPTH (tpt_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (push_valid),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (pix_valid),
        .out_ready (pop),
        .out_data  (pix_data)
    );

    always_comb begin
        next_s     = s;
        push_valid = 1'b0;
        push_data  = '0;
        pop        = 1'b0;
        next_s.wr_prev = host_bus.wr_n;
        if (!s.strap_taken) begin
            next_s.strap       = bus_width_strap;
            next_s.strap_taken = 1'b1;
        end
        if (wr_rise && !host_bus.dc) begin
            next_s.addr = host_bus.md[7:0];
        end else if (wr_rise) begin
            unique case (s.addr)
                tpt_pkg::ADDR_LINE_ACTIVE_WIDTH:     next_s.r_width = host_bus.md[7:0];
                tpt_pkg::ADDR_LINE_BLANKING_LENGTH:  next_s.r_hblank = host_bus.md[7:0];
                tpt_pkg::ADDR_FRAME_HEIGHT_LOW:      next_s.r_hlow = host_bus.md[7:0];
                tpt_pkg::ADDR_FRAME_HEIGHT_HIGH:     next_s.r_hhigh = host_bus.md[7:0];
                tpt_pkg::ADDR_FRAME_BLANKING_LENGTH: next_s.r_vblank = host_bus.md[7:0];
                tpt_pkg::ADDR_LINE_SYNC_WIDTH:       next_s.r_hsw = host_bus.md[7:0];
                tpt_pkg::ADDR_LINE_SYNC_START:       next_s.r_hps = host_bus.md[7:0];
                tpt_pkg::ADDR_FRAME_SYNC_WIDTH:      next_s.r_vsw = host_bus.md[7:0];
                tpt_pkg::ADDR_FRAME_SYNC_START:      next_s.r_vps = host_bus.md[7:0];
                tpt_pkg::ADDR_SYNC_POLARITY:         next_s.r_pol = host_bus.md[7:0];
                tpt_pkg::ADDR_POWER_SAVE_CONTROL:    next_s.r_ps = host_bus.md[7:0];
                tpt_pkg::ADDR_GAMMA_TABLE_DATA: begin
                    next_s.r_gamma     = host_bus.md[7:0];
                    next_s.gamma_index = s.gamma_index + 8'h01;
                end
                tpt_pkg::ADDR_FRAME_MEMORY_PORT_LOW: begin
                    // Wide strap takes a whole word; narrow pairs low then high
                    if (s.strap) begin
                        push_valid = 1'b1;
                        push_data  = expand(host_bus.md);
                    end else if (s.byte_phase) begin
                        push_valid = 1'b1;
                        push_data  = expand({host_bus.md[7:0], s.r_mem_low});
                    end else begin
                        next_s.r_mem_low = host_bus.md[7:0];
                    end
                    next_s.byte_phase = !s.strap && !s.byte_phase;
                end
                tpt_pkg::ADDR_FRAME_MEMORY_PORT_HIGH: begin
                    push_valid = 1'b1;
                    push_data  = expand({host_bus.md[7:0], s.r_mem_low});
                    next_s.byte_phase = 1'b0;
                end
                default: ;
            endcase
            if (push_valid && fifo_ready) begin
                next_s.mem_addr = s.mem_addr + 17'h00001;
            end
            if (s.addr != tpt_pkg::ADDR_FRAME_MEMORY_PORT_LOW &&
                s.addr != tpt_pkg::ADDR_FRAME_MEMORY_PORT_HIGH &&
                s.addr != tpt_pkg::ADDR_GAMMA_TABLE_DATA) begin
                next_s.addr = s.addr + 8'h01;
            end
        end
        next_s.md_out = {8'h00, reg_read(s)};

        htotal = 11'({s.r_width[6:0], 3'b000}) + 11'(s.r_hblank[6:0]);
        de_h0  = 11'(s.r_hblank[6:0]) - 11'(s.r_hps[6:0]);
        fs_point = htotal - 11'(s.r_hps[6:0]);
        vtotal = 11'({s.r_hhigh[1:0], s.r_hlow}) + 11'(s.r_vblank);
        de_v0  = 11'(s.r_vblank) - 11'(s.r_vps);
        ps_on  = (next_s.r_ps[1:0] != 2'b00);

        if (ps_on) begin
            // Counters parked so the panel restarts at a line start
            next_s.div    = 2'h0;
            next_s.h      = 11'h000;
            next_s.v      = 11'h000;
            next_s.fs_low = 1'b0;
        end else if (tick) begin
            next_s.div = 2'h0;
            if (s.h + 11'h001 >= htotal) begin
                next_s.h = 11'h000;
                next_s.v = (s.v + 11'h001 >= vtotal) ? 11'h000
                                                      : s.v + 11'h001;
            end else begin
                next_s.h = s.h + 11'h001;
            end
        end else begin
            next_s.div = s.div + 2'h1;
        end
        vn = (next_s.v + 11'h001 >= vtotal) ? 11'h000 : next_s.v + 11'h001;
        if (!ps_on && tick && next_s.h == fs_point) begin
            next_s.fs_low = (vn < 11'(s.r_vsw[6:0]));
        end

        hs_act = (next_s.h < 11'(s.r_hsw[6:0]));
        de_act = (next_s.h >= de_h0) &&
                 (next_s.h < de_h0 + 11'({s.r_width[6:0], 3'b000})) &&
                 (next_s.v >= de_v0) &&
                 (next_s.v < de_v0 + 11'({s.r_hhigh[1:0], s.r_hlow}));

        if (ps_on) begin
            next_s.panel = '0;
        end else begin
            // Launch at the pixel clock's inactive edge for half-period margins
            next_s.panel.pclk = (next_s.div >= tpt_pkg::PIXEL_DIV_HALF) ^
                                s.r_pol[tpt_pkg::POL_PCLK_BIT];
            next_s.panel.line_sync  = !hs_act ^ s.r_pol[tpt_pkg::POL_LINE_BIT];
            next_s.panel.frame_sync = !next_s.fs_low ^
                                      s.r_pol[tpt_pkg::POL_FRAME_BIT];
            next_s.panel.data_enable = de_act;
            if (tick || !s.panel.data_enable) begin
                // Underrun shows black rather than stalling the panel
                pop = de_act && pix_valid;
                next_s.panel.pixel_data = pop ? pix_data : '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
            // Strobe idles high, so no false write edge follows reset
            s.wr_prev <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic ps_reg, pclk_lvl, hs_lvl;
    assign ps_reg   = (s.r_ps[1:0] != 2'b00);
    assign pclk_lvl = s.panel.pclk ^ s.r_pol[tpt_pkg::POL_PCLK_BIT];
    assign hs_lvl   = s.panel.line_sync ^ s.r_pol[tpt_pkg::POL_LINE_BIT];

    sequence s_pclk_high;
        pclk_lvl [*2];
    endsequence
    sequence s_pclk_low;
        !pclk_lvl [*2];
    endsequence

    property p_ps_low;
        ps_reg |-> (s.panel == '0);
    endproperty
    property p_resume;
        $fell(ps_reg) && s.r_hsw[6:0] != 7'h00 |-> (hs_lvl == 1'b0);
    endproperty
    // A polarity write skews the level for one cycle, and $rose looks one back
    property p_pclk_duty;
        $rose(pclk_lvl) && (s.r_pol == $past(s.r_pol, 2)) |->
            s_pclk_high ##1 s_pclk_low;
    endproperty
    property p_div;
        tick && !ps_on |=> (s.div == 2'h0) ##1 (s.div == 2'h1);
    endproperty
    property p_line_wrap;
        !ps_on && tick && (s.h + 11'h001 >= htotal) |=> (s.h == 11'h000);
    endproperty
    property p_hs_width;
        !ps_reg && !$past(sys_rst) && $stable(s.r_pol) && $stable(s.r_hsw)
            |-> (hs_lvl == !(s.h < 11'(s.r_hsw[6:0])));
    endproperty
    property p_addr_inc;
        wr_rise && host_bus.dc && s.addr == tpt_pkg::ADDR_LINE_SYNC_WIDTH
            |=> (s.addr == tpt_pkg::ADDR_LINE_SYNC_WIDTH + 8'h01);
    endproperty
    property p_gamma_hold;
        wr_rise && host_bus.dc && s.addr == tpt_pkg::ADDR_GAMMA_TABLE_DATA
            |=> (s.addr == tpt_pkg::ADDR_GAMMA_TABLE_DATA) &&
                (s.gamma_index == $past(s.gamma_index) + 8'h01);
    endproperty
    property p_reset_zero;
        $past(sys_rst) && !sys_rst |->
            (s.r_width == 8'h00) && (s.r_ps == 8'h00);
    endproperty

    a_ps_low: assert property (p_ps_low)
        else $error("panel not low in power save");
    a_resume: assert property (p_resume)
        else $error("line sync not restored after power save");
    a_pclk_duty: assert property (
        disable iff (sys_rst || ps_reg) p_pclk_duty)
        else $error("pixel clock duty wrong");
    a_div: assert property (disable iff (sys_rst || ps_reg) p_div)
        else $error("pixel divider wrong");
    a_line_wrap: assert property (p_line_wrap)
        else $error("line did not wrap at total");
    a_hs_width: assert property (p_hs_width)
        else $error("line sync width wrong");
    a_addr_inc: assert property (p_addr_inc)
        else $error("register address did not advance");
    a_gamma_hold: assert property (p_gamma_hold)
        else $error("gamma port address moved");
    a_reset_zero: assert property (disable iff (1'b0) p_reset_zero)
        else $error("register not zero after reset");
endmodule : tpt_timing

/* File: tpt_panel_model.sv */
// Panel-side monitor: measures sync, enable and pixel clock spacing.
// Assumes registered panel outputs; pol undoes the chosen polarities.
`timescale 1ns/1ps

module tpt_panel_model (
    input  wire logic                   clk,
    input  wire tpt_pkg::tpt_panel_type panel,
    input  wire logic [2:0]             pol,
    input  wire logic                   chk,
    output int                          m [11]
);
    logic pc;
    logic ls;
    logic fs;
    logic de;
    logic pc_d = 0;
    logic ls_d = 0;
    logic de_d = 0;
    logic ls_p = 1;
    logic de_p = 0;
    logic fs_p = 1;
    logic fsp  = 0;
    int   r_m [11] = '{default: 0};
    int   pcnt = 0;
    int   hs_t = 0;
    int   de_t = 0;
    int   fs_t = 0;
    int   lines = 0;
    int   fs_l = 0;
    int   ck = 0;

    assign m  = r_m;
    assign pc = panel.pclk ^ pol[0];
    assign ls = panel.line_sync ^ pol[1];
    assign fs = panel.frame_sync ^ pol[2];
    assign de = panel.data_enable;

    always @(posedge clk) begin
        pc_d <= pc;
        ls_d <= ls;
        de_d <= de;
        ck <= (pc != pc_d) ? 1 : ck + 1;
        if (!pc && pc_d) r_m[7] <= ck;
        // Panel samples on the active edge, so launches must sit on the other
        if (chk && (ls != ls_d || de != de_d) && !(pc_d && !pc)) begin
            r_m[9] <= r_m[9] + 1;
        end
        if (pc && !pc_d) begin
            pcnt <= pcnt + 1;
            ls_p <= ls;
            de_p <= de;
            fs_p <= fs;
            if (!ls && ls_p) begin
                r_m[0] <= pcnt - hs_t;
                hs_t <= pcnt;
                lines <= lines + 1;
                fsp <= 0;
                if (fsp) r_m[4] <= pcnt - fs_t;
            end
            if (ls && !ls_p) r_m[1] <= pcnt - hs_t;
            if (de && !de_p) begin
                r_m[2] <= pcnt - hs_t;
                de_t <= pcnt;
            end
            if (!de && de_p) r_m[3] <= pcnt - de_t;
            if (!fs && fs_p) begin
                r_m[5] <= lines - fs_l;
                r_m[8] <= r_m[8] + 1;
                fs_l <= lines;
                fs_t <= pcnt;
                fsp <= 1;
            end
            if (fs && !fs_p) r_m[6] <= lines - fs_l;
            // First pixel of a line that carries data
            if (de && !de_p && panel.pixel_data != 0)
                r_m[10] <= panel.pixel_data;
        end
    end
endmodule : tpt_panel_model

/* File: tb_tft_panel_timing_generator.sv */
// Self-checking bench for the panel timing generator.
// Assumes the host bus is driven synchronously, 1 ns after clk rises.
`timescale 1ns/1ps

module tb_tft_panel_timing_generator;
    logic                   clk = 0;
    logic                   sys_rst = 1;
    logic                   strap = 0;
    logic                   chk = 0;
    logic [2:0]             pol = 0;
    tpt_pkg::tpt_bus_type   host_bus = '{1'b1, 1'b0, 1'b1, 1'b1, 16'h0000};
    logic [15:0]            md_out;
    logic                   md_oe;
    logic                   mem_ready;
    tpt_pkg::tpt_panel_type panel;
    int                     m [11];
    logic [7:0]             r [9];
    int                     err_count = 0;
    int                     samples_checked = 0;
    int                     k;
    logic [15:0]            w0;

    // Far slower than the device minimum, well clear of the lower bound
    always #50 clk = ~clk;

    tpt_timing u_dut (.clk(clk), .sys_rst(sys_rst), .host_bus(host_bus),
        .bus_width_strap(strap), .md_out(md_out), .md_oe(md_oe),
        .mem_ready(mem_ready), .panel(panel));
    tpt_panel_model u_panel (.clk(clk), .panel(panel), .pol(pol),
        .chk(chk), .m(m));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic bus_wr(input logic dc, input logic [15:0] d);
        @(posedge clk) #1;
        host_bus.cs_n = 0;
        host_bus.dc = dc;
        host_bus.md = d;
        host_bus.wr_n = 0;
        @(posedge clk) #1;
        host_bus.wr_n = 1;
        @(posedge clk) #1;
        host_bus.cs_n = 1;
    endtask : bus_wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus_wr(0, {8'h00, a});
        @(posedge clk) #1;
        host_bus.cs_n = 0;
        host_bus.dc = 1;
        host_bus.rd_n = 0;
        repeat (2) @(posedge clk);
        #1;
        check(md_oe, 1);
        check(md_out, {8'h00, e});
        host_bus.rd_n = 1;
        host_bus.cs_n = 1;
    endtask : rd

    task automatic wait_frames(input int n);
        int t;
        t = m[8] + n;
        for (int i = 0; i < 40000 && m[8] < t; i++) @(posedge clk);
        if (m[8] < t) begin
            err_count++;
            give_verdict();
        end
    endtask : wait_frames

    function automatic int line_len();
        return r[0] * 8 + r[1];
    endfunction : line_len

    // 5-6-5 to 6-6-6: each short field gains a copy of its top bit
    function automatic int exp_pix(input logic [15:0] w);
        return {w[15:11], w[15], w[10:5], w[4:0], w[4]};
    endfunction : exp_pix

    task automatic cfg;
        // Rewrites move edges off the launch phase; watch only when settled
        chk = 0;
        bus_wr(0, 16'h0016);
        // Odd places are unmapped; junk there must not land anywhere
        for (int i = 0; i < 17; i++) begin
            bus_wr(1, (i % 2) ? 16'($urandom % 256) : {8'h00, r[i/2]});
        end
        for (int i = 0; i < 9; i++) rd(8'h16 + 8'(2 * i), r[i]);
        chk = 1;
        wait_frames(2);
        check(m[0], line_len());
        check(m[1], r[5]);
        check(m[2], r[1] - r[6]);
        check(m[3], r[0] * 8);
        check(m[4], r[6]);
        check(m[5], {r[3][1:0], r[2]} + r[4]);
        check(m[6], r[7]);
        check(m[7], 2);
        $display("timing test done");
    endtask : cfg

    initial begin
        void'($urandom(32'hF079B593));
        repeat (3) @(posedge clk);
        #1 sys_rst = 0;
        @(posedge clk);
        for (int i = 0; i < 9; i++) rd(8'h16 + 8'(2 * i), 8'h00);
        rd(8'h28, 8'h00);
        rd(8'h56, 8'h00);
        rd(8'h31, 8'h00);
        bus_wr(0, 16'h0054);
        bus_wr(1, 16'h005A);
        bus_wr(1, 16'h00A5);
        rd(8'h54, 8'hA5);
        $display("reset test done");
        r = '{8'h01, 8'h03, 8'h00, 8'h01, 8'h02, 8'h01, 8'h02, 8'h01, 8'h01};
        cfg();
        r[6] = 8'(1 + $urandom % 3);
        r[1] = r[6] + 8'(1 + $urandom % 4);
        r[0] = 8'(1 + $urandom % 2);
        r[5] = 8'(1 + $urandom % 2);
        r[2] = 8'(2 + $urandom % 3);
        r[3] = 8'h00;
        r[4] = 8'(2 + $urandom % 2);
        cfg();
        check(m[9], 0);
        chk = 0;
        bus_wr(0, 16'h0028);
        bus_wr(1, 16'h0007);
        pol = 3'h7;
        wait_frames(2);
        check(m[0], line_len());
        check(m[1], r[5]);
        check(m[7], 2);
        $display("polarity test done");
        for (int ps = 1; ps < 3; ps++) begin
            bus_wr(0, 16'h0056);
            bus_wr(1, 16'(ps));
            check(panel, 0);
            if (ps == 1) begin
                bus_wr(0, 16'h0048);
                for (int i = 0; i < 8; i++) begin
                    if (i == 6) check(mem_ready, 1);
                    bus_wr(1, 16'h00F0 + 16'(i));
                end
                check(mem_ready, 0);
                check(panel, 0);
            end
            bus_wr(0, 16'h0056);
            bus_wr(1, 16'h0000);
            for (k = 0; k < 8 && panel.pclk === 1'b0; k++) @(posedge clk);
            check(k < 8, 1);
            wait_frames(1);
            check(mem_ready, 1);
            check(m[10], exp_pix(16'hF1F0));
            $display("power save test done");
        end
        // Strap is caught only after reset, so the wide port needs one
        @(posedge clk) #1;
        strap = 1;
        pol = 3'h0;
        sys_rst = 1;
        repeat (3) @(posedge clk);
        #1 sys_rst = 0;
        rd(8'h28, 8'h00);
        cfg();
        check(m[9], 0);
        chk = 0;
        bus_wr(0, 16'h0056);
        bus_wr(1, 16'h0001);
        bus_wr(0, 16'h0048);
        w0 = 16'($urandom) | 16'h8000;
        for (int i = 0; i < 4; i++) begin
            check(mem_ready, 1);
            bus_wr(1, (i == 0) ? w0 : 16'($urandom));
        end
        check(mem_ready, 0);
        bus_wr(0, 16'h0056);
        bus_wr(1, 16'h0000);
        wait_frames(1);
        check(m[10], exp_pix(w0));
        check(mem_ready, 1);
        $display("wide port test done");
        give_verdict();
    end
endmodule : tb_tft_panel_timing_generator
